// >>> hdl/control_inherent_op_decoder.sv
`timescale 1ns/1ps
`default_nettype none

module control_inherent_op_decoder #(
	parameter int DIRS = 8,
	parameter int STACK_DEPTH = 16
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic instrValid,
	input wire logic [13:0] instr,
	output logic instrReady,
	output logic [14:0] pcOut,
	output logic [15:0] memAddr,
	input wire logic [7:0] memRdData,
	output logic [7:0] memWrData,
	output logic memWrEn,
	output logic [7:0] workOut,
	output logic carryFlag,
	output logic halfCarryFlag,
	output logic zeroFlag,
	output logic watchdogExpiredFlag,
	output logic powerDownFlag,
	output logic intEnable,
	output logic [7:0] prescalerConfig,
	output logic [DIRS-1:0][7:0] dirRegs,
	output logic wdtClear,
	output logic standbyReq,
	output logic softResetReq
);

	typedef struct packed {
		decoder_pkg::state_t st;
		logic [1:0] phase;
		logic [13:0] ir;
		logic [14:0] pc;
		logic [7:0] work;
		logic carry;
		logic halfCarry;
		logic zero;
		logic wdtExpired;
		logic powerDown;
		logic intEn;
		logic [7:0] prescaler;
		logic [DIRS-1:0][7:0] dirs;
		logic [1:0][15:0] ptr;
		logic [15:0] memAddr;
		logic [7:0] memWrData;
		logic memWrEn;
		logic ready;
		logic wdtClear;
		logic standby;
		logic softReset;
	} regs_t;

	regs_t r;
	regs_t n;
	decoder_pkg::op_t op;
	logic commit;
	logic push;
	logic pop;
	logic [14:0] stackTop;

	function automatic logic [15:0] sext6(input logic [5:0] k);
		return {{10{k[5]}}, k};
	endfunction : sext6

	function automatic logic [14:0] relTarget(input logic [14:0] pc, input logic [8:0] k);
		return pc + {{6{k[8]}}, k};
	endfunction : relTarget

	assign op = decoder_pkg::decodeOp(r.ir);
	assign commit = (r.st == decoder_pkg::ST_EXEC) && (r.phase == decoder_pkg::LAST_PHASE);
	assign push = commit && (op == decoder_pkg::OP_SUBROUTINE_CALL ||
		op == decoder_pkg::OP_SUBROUTINE_BY_WORKING);
	assign pop = commit && (op == decoder_pkg::OP_RETURN || op == decoder_pkg::OP_INTERRUPT_EXIT ||
		op == decoder_pkg::OP_RETURN_WITH_LITERAL);

	return_stack #(
		.DEPTH(STACK_DEPTH),
		.WIDTH(15)
	) stack (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.push(push),
		.pop(pop),
		.pushData(r.pc),
		.top(stackTop)
	);

	always_comb
	begin
		logic sel;
		logic window;
		logic [15:0] stepped;
		logic [15:0] effAddr;
		logic [7:0] res;
		logic [8:0] sum;
		logic [4:0] nib;
		sel = 1'b0;
		window = 1'b0;
		stepped = 16'h0000;
		effAddr = 16'h0000;
		res = 8'h00;
		sum = 9'h000;
		nib = 5'h00;
		n = r;
		n.phase = r.phase + 2'h1;
		n.memWrEn = 1'b0;
		n.wdtClear = 1'b0;
		n.standby = 1'b0;
		n.softReset = 1'b0;
		// Pointer select and the address that the indirect window resolves to.
		unique case (op)
			decoder_pkg::OP_INDIRECT_LOAD_MOD, decoder_pkg::OP_INDIRECT_STORE_MOD:
			begin
				sel = r.ir[2];
				window = 1'b1;
				stepped = r.ir[0] ? r.ptr[sel] - 16'h0001 : r.ptr[sel] + 16'h0001;
				effAddr = r.ir[1] ? r.ptr[sel] : stepped;
			end
			decoder_pkg::OP_INDIRECT_LOAD_IDX, decoder_pkg::OP_INDIRECT_STORE_IDX:
			begin
				sel = r.ir[6];
				window = 1'b1;
				effAddr = r.ptr[sel] + sext6(r.ir[5:0]);
			end
			decoder_pkg::OP_AND_FILE:
			begin
				sel = r.ir[0];
				window = (r.ir[6:0] == decoder_pkg::WINDOW0_ADDR) ||
					(r.ir[6:0] == decoder_pkg::WINDOW1_ADDR);
				effAddr = window ? r.ptr[sel] : {9'h000, r.ir[6:0]};
			end
			default:
			begin
				sel = r.ir[6];
			end
		endcase
		unique case (r.st)
			decoder_pkg::ST_IDLE:
			begin
				if (r.phase == decoder_pkg::FIRST_PHASE && instrValid)
				begin
					n.ir = instr;
					n.pc = r.pc + 15'h0001;
					n.st = decoder_pkg::ST_EXEC;
				end
			end
			decoder_pkg::ST_EXEC:
			begin
				if (r.phase == decoder_pkg::ADDR_PHASE)
					n.memAddr = effAddr;
				if (r.phase == decoder_pkg::LAST_PHASE)
				begin
					n.st = decoder_pkg::ST_IDLE;
					unique case (op)
						decoder_pkg::OP_RELATIVE_JUMP:
							n.pc = relTarget(r.pc, r.ir[8:0]);
						decoder_pkg::OP_JUMP_BY_WORKING:
							n.pc = r.pc + {7'h00, r.work};
						decoder_pkg::OP_SUBROUTINE_BY_WORKING:
							n.pc = {r.pc[14:8], r.work};
						decoder_pkg::OP_SUBROUTINE_CALL, decoder_pkg::OP_ABSOLUTE_JUMP:
							n.pc = {r.pc[14:11], r.ir[10:0]};
						decoder_pkg::OP_INTERRUPT_EXIT:
						begin
							n.pc = stackTop;
							n.intEn = 1'b1;
						end
						decoder_pkg::OP_RETURN:
							n.pc = stackTop;
						decoder_pkg::OP_RETURN_WITH_LITERAL:
						begin
							n.pc = stackTop;
							n.work = r.ir[7:0];
						end
						decoder_pkg::OP_KICK_WATCHDOG:
						begin
							n.wdtClear = 1'b1;
							n.wdtExpired = 1'b1;
							n.powerDown = 1'b1;
						end
						decoder_pkg::OP_SLEEP:
						begin
							n.standby = 1'b1;
							n.wdtExpired = 1'b1;
							n.powerDown = 1'b0;
						end
						decoder_pkg::OP_LOAD_PRESCALER:
							n.prescaler = r.work;
						decoder_pkg::OP_SOFT_RESET:
							n.softReset = 1'b1;
						decoder_pkg::OP_LOAD_DIRECTION:
							n.dirs[r.ir[2:0]] = r.work;
						decoder_pkg::OP_POINTER_ADD:
							n.ptr[sel] = r.ptr[sel] + sext6(r.ir[5:0]);
						decoder_pkg::OP_INDIRECT_LOAD_MOD, decoder_pkg::OP_INDIRECT_LOAD_IDX:
						begin
							n.work = memRdData;
							n.zero = (memRdData == 8'h00);
						end
						decoder_pkg::OP_INDIRECT_STORE_MOD, decoder_pkg::OP_INDIRECT_STORE_IDX:
						begin
							n.memWrEn = 1'b1;
							n.memWrData = r.work;
						end
						decoder_pkg::OP_AND_LITERAL:
						begin
							res = r.work & r.ir[7:0];
							n.work = res;
							n.zero = (res == 8'h00);
						end
						decoder_pkg::OP_ADD_LITERAL:
						begin
							sum = {1'b0, r.work} + {1'b0, r.ir[7:0]};
							nib = {1'b0, r.work[3:0]} + {1'b0, r.ir[3:0]};
							n.work = sum[7:0];
							n.carry = sum[8];
							n.halfCarry = nib[4];
							n.zero = (sum[7:0] == 8'h00);
						end
						decoder_pkg::OP_AND_FILE:
						begin
							res = r.work & memRdData;
							n.zero = (res == 8'h00);
							if (r.ir[7])
							begin
								n.memWrEn = 1'b1;
								n.memWrData = res;
							end
							else
								n.work = res;
						end
						default:
						begin
						end
					endcase
					// The step lands whether the modifier is pre or post; only the address differs.
					if (op == decoder_pkg::OP_INDIRECT_LOAD_MOD ||
						op == decoder_pkg::OP_INDIRECT_STORE_MOD)
						n.ptr[sel] = stepped;
					if (op == decoder_pkg::OP_RELATIVE_JUMP || op == decoder_pkg::OP_SUBROUTINE_CALL ||
						op == decoder_pkg::OP_ABSOLUTE_JUMP || op == decoder_pkg::OP_JUMP_BY_WORKING ||
						op == decoder_pkg::OP_SUBROUTINE_BY_WORKING || push || pop)
						n.st = decoder_pkg::ST_FLUSH;
					else if (window && r.ptr[sel][15])
						n.st = decoder_pkg::ST_EXTRA;
				end
			end
			decoder_pkg::ST_FLUSH, decoder_pkg::ST_EXTRA:
			begin
				if (r.phase == decoder_pkg::LAST_PHASE)
					n.st = decoder_pkg::ST_IDLE;
			end
		endcase
		n.ready = (n.st == decoder_pkg::ST_IDLE) && (n.phase == decoder_pkg::FIRST_PHASE);
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			r <= '0;
			r.st <= decoder_pkg::ST_IDLE;
			r.pc <= decoder_pkg::PC_RESET;
			r.work <= decoder_pkg::WORK_RESET;
			r.wdtExpired <= decoder_pkg::WDT_EXPIRED_RESET;
			r.powerDown <= decoder_pkg::POWER_DOWN_RESET;
			r.prescaler <= decoder_pkg::PRESCALER_RESET;
			r.dirs <= {DIRS{decoder_pkg::DIRECTION_RESET}};
			r.ptr <= {2{decoder_pkg::POINTER_RESET}};
			r.ready <= 1'b1;
		end
		else
			r <= n;
	end

	assign instrReady = r.ready;
	assign pcOut = r.pc;
	assign memAddr = r.memAddr;
	assign memWrData = r.memWrData;
	assign memWrEn = r.memWrEn;
	assign workOut = r.work;
	assign carryFlag = r.carry;
	assign halfCarryFlag = r.halfCarry;
	assign zeroFlag = r.zero;
	assign watchdogExpiredFlag = r.wdtExpired;
	assign powerDownFlag = r.powerDown;
	assign intEnable = r.intEn;
	assign prescalerConfig = r.prescaler;
	assign dirRegs = r.dirs;
	assign wdtClear = r.wdtClear;
	assign standbyReq = r.standby;
	assign softResetReq = r.softReset;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);

	sequence idleCycleThenReady(decoder_pkg::state_t s);
		(r.st == s) [*4] ##1 instrReady;
	endsequence

	branch_flush_a: assert property (commit && n.st == decoder_pkg::ST_FLUSH |=>
		idleCycleThenReady(decoder_pkg::ST_FLUSH)) else $error("Branch did not take two cycles.");
	window_extra_a: assert property (commit && n.st == decoder_pkg::ST_EXTRA |=>
		idleCycleThenReady(decoder_pkg::ST_EXTRA)) else $error("Extra cycle missing.");
	relative_target_a: assert property (commit && op == decoder_pkg::OP_RELATIVE_JUMP |=>
		pcOut == relTarget($past(r.pc), $past(r.ir[8:0]))) else $error("Bad jump target.");
	pointer_wrap_a: assert property (commit && op == decoder_pkg::OP_POINTER_ADD |=>
		r.ptr[$past(r.ir[6])] == $past(r.ptr[r.ir[6]]) + sext6($past(r.ir[5:0])))
		else $error("Pointer add wrong.");
	and_literal_a: assert property (commit && op == decoder_pkg::OP_AND_LITERAL |=>
		workOut == ($past(r.work) & $past(r.ir[7:0])) && zeroFlag == (workOut == 8'h00))
		else $error("Literal AND wrong.");
	add_carry_a: assert property (commit && op == decoder_pkg::OP_ADD_LITERAL |=>
		{carryFlag, workOut} == {1'b0, $past(r.work)} + {1'b0, $past(r.ir[7:0])})
		else $error("Literal add wrong.");
	watchdog_kick_a: assert property (commit && op == decoder_pkg::OP_KICK_WATCHDOG |=>
		wdtClear && watchdogExpiredFlag && powerDownFlag ##1 !wdtClear)
		else $error("Watchdog kick wrong.");
	soft_reset_a: assert property (commit && op == decoder_pkg::OP_SOFT_RESET |=>
		softResetReq && instrReady ##1 !softResetReq) else $error("Reset request wrong.");
	indexed_store_a: assert property (commit && op == decoder_pkg::OP_INDIRECT_STORE_IDX |=>
		memWrEn && memWrData == $past(r.work) && $stable(zeroFlag)) else $error("Store wrong.");
	retlit_value_a: assert property (commit && op == decoder_pkg::OP_RETURN_WITH_LITERAL |=>
		workOut == $past(r.ir[7:0]) && pcOut == $past(stackTop)) else $error("Return literal wrong.");

endmodule : control_inherent_op_decoder

`default_nettype wire

// >>> hdl/return_stack.sv
`timescale 1ns/1ps
`default_nettype none

// Overflow wraps and silently overwrites the oldest entry, as software must nest within DEPTH.
module return_stack #(
	parameter int DEPTH = 16,
	parameter int WIDTH = 15
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic push,
	input wire logic pop,
	input wire logic [WIDTH-1:0] pushData,
	output logic [WIDTH-1:0] top
);

	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] sp;
	} stack_t;

	stack_t r;
	stack_t n;

	always_comb
	begin
		n = r;
		if (push)
		begin
			n.mem[r.sp] = pushData;
			n.sp = r.sp + 1'b1;
		end
		else if (pop)
		begin
			n.sp = r.sp - 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			r <= '0;
		else
			r <= n;
	end

	assign top = r.mem[r.sp - 1'b1];

endmodule : return_stack

`default_nettype wire

// >>> include/decoder_pkg.sv
`default_nettype none

package decoder_pkg;

	// One instruction cycle is four system clocks; the phase counter is the divider.
	localparam int CLOCKS_PER_CYCLE = 4;
	localparam logic [1:0] FIRST_PHASE = 2'h0;
	localparam logic [1:0] ADDR_PHASE = 2'h1;
	localparam logic [1:0] LAST_PHASE = 2'h3;

	localparam logic [14:0] PC_RESET = 15'h0000;
	localparam logic [7:0] WORK_RESET = 8'h00;
	localparam logic [7:0] PRESCALER_RESET = 8'hff;
	localparam logic [7:0] DIRECTION_RESET = 8'hff;
	localparam logic [15:0] POINTER_RESET = 16'h0000;
	localparam logic WDT_EXPIRED_RESET = 1'b1;
	localparam logic POWER_DOWN_RESET = 1'b1;

	localparam logic [6:0] WINDOW0_ADDR = 7'h00;
	localparam logic [6:0] WINDOW1_ADDR = 7'h01;

	localparam logic [1:0] MOD_PRE_INC = 2'h0;
	localparam logic [1:0] MOD_PRE_DEC = 2'h1;
	localparam logic [1:0] MOD_POST_INC = 2'h2;
	localparam logic [1:0] MOD_POST_DEC = 2'h3;

	localparam logic [13:0] MASK_FULL = 14'h3fff;
	localparam logic [13:0] MASK_3BIT = 14'h3ff8;
	localparam logic [13:0] MASK_7BIT = 14'h3f80;
	localparam logic [13:0] MASK_8BIT = 14'h3f00;
	localparam logic [13:0] MASK_9BIT = 14'h3e00;
	localparam logic [13:0] MASK_11BIT = 14'h3800;

	localparam logic [13:0] OPC_RELATIVE_JUMP = 14'h3200;
	localparam logic [13:0] OPC_SUBROUTINE_CALL = 14'h2000;
	localparam logic [13:0] OPC_ABSOLUTE_JUMP = 14'h2800;
	localparam logic [13:0] OPC_JUMP_BY_WORKING = 14'h000b;
	localparam logic [13:0] OPC_SUBROUTINE_BY_WORKING = 14'h000a;
	localparam logic [13:0] OPC_INTERRUPT_EXIT = 14'h0009;
	localparam logic [13:0] OPC_RETURN = 14'h0008;
	localparam logic [13:0] OPC_SOFT_RESET = 14'h0001;
	localparam logic [13:0] OPC_KICK_WATCHDOG = 14'h0064;
	localparam logic [13:0] OPC_SLEEP = 14'h0063;
	localparam logic [13:0] OPC_LOAD_PRESCALER = 14'h0062;
	localparam logic [13:0] OPC_LOAD_DIRECTION = 14'h0060;
	localparam logic [13:0] OPC_INDIRECT_LOAD_MOD = 14'h0010;
	localparam logic [13:0] OPC_INDIRECT_STORE_MOD = 14'h0018;
	localparam logic [13:0] OPC_POINTER_ADD = 14'h3100;
	localparam logic [13:0] OPC_INDIRECT_LOAD_IDX = 14'h3f00;
	localparam logic [13:0] OPC_INDIRECT_STORE_IDX = 14'h3f80;
	localparam logic [13:0] OPC_RETURN_WITH_LITERAL = 14'h3400;
	localparam logic [13:0] OPC_AND_LITERAL = 14'h3900;
	localparam logic [13:0] OPC_ADD_LITERAL = 14'h3e00;
	localparam logic [13:0] OPC_AND_FILE = 14'h0500;

	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_FLUSH, ST_EXTRA} state_t;

	typedef enum logic [4:0] {
		OP_OTHER, OP_RELATIVE_JUMP, OP_SUBROUTINE_CALL, OP_ABSOLUTE_JUMP,
		OP_JUMP_BY_WORKING, OP_SUBROUTINE_BY_WORKING, OP_INTERRUPT_EXIT, OP_RETURN,
		OP_RETURN_WITH_LITERAL, OP_SOFT_RESET, OP_KICK_WATCHDOG, OP_SLEEP,
		OP_LOAD_PRESCALER, OP_LOAD_DIRECTION, OP_INDIRECT_LOAD_MOD, OP_INDIRECT_STORE_MOD,
		OP_POINTER_ADD, OP_INDIRECT_LOAD_IDX, OP_INDIRECT_STORE_IDX, OP_AND_LITERAL,
		OP_ADD_LITERAL, OP_AND_FILE
	} op_t;

	// Specific full patterns are tested before the direction group that overlaps them.
	function automatic op_t decodeOp(input logic [13:0] ir);
		op_t op;
		op = OP_OTHER;
		if ((ir & MASK_FULL) == OPC_JUMP_BY_WORKING) op = OP_JUMP_BY_WORKING;
		else if ((ir & MASK_FULL) == OPC_SUBROUTINE_BY_WORKING) op = OP_SUBROUTINE_BY_WORKING;
		else if ((ir & MASK_FULL) == OPC_INTERRUPT_EXIT) op = OP_INTERRUPT_EXIT;
		else if ((ir & MASK_FULL) == OPC_RETURN) op = OP_RETURN;
		else if ((ir & MASK_FULL) == OPC_SOFT_RESET) op = OP_SOFT_RESET;
		else if ((ir & MASK_FULL) == OPC_KICK_WATCHDOG) op = OP_KICK_WATCHDOG;
		else if ((ir & MASK_FULL) == OPC_SLEEP) op = OP_SLEEP;
		else if ((ir & MASK_FULL) == OPC_LOAD_PRESCALER) op = OP_LOAD_PRESCALER;
		else if ((ir & MASK_3BIT) == OPC_LOAD_DIRECTION) op = OP_LOAD_DIRECTION;
		else if ((ir & MASK_3BIT) == OPC_INDIRECT_LOAD_MOD) op = OP_INDIRECT_LOAD_MOD;
		else if ((ir & MASK_3BIT) == OPC_INDIRECT_STORE_MOD) op = OP_INDIRECT_STORE_MOD;
		else if ((ir & MASK_7BIT) == OPC_POINTER_ADD) op = OP_POINTER_ADD;
		else if ((ir & MASK_7BIT) == OPC_INDIRECT_LOAD_IDX) op = OP_INDIRECT_LOAD_IDX;
		else if ((ir & MASK_7BIT) == OPC_INDIRECT_STORE_IDX) op = OP_INDIRECT_STORE_IDX;
		else if ((ir & MASK_8BIT) == OPC_RETURN_WITH_LITERAL) op = OP_RETURN_WITH_LITERAL;
		else if ((ir & MASK_8BIT) == OPC_AND_LITERAL) op = OP_AND_LITERAL;
		else if ((ir & MASK_8BIT) == OPC_ADD_LITERAL) op = OP_ADD_LITERAL;
		else if ((ir & MASK_8BIT) == OPC_AND_FILE) op = OP_AND_FILE;
		else if ((ir & MASK_9BIT) == OPC_RELATIVE_JUMP) op = OP_RELATIVE_JUMP;
		else if ((ir & MASK_11BIT) == OPC_SUBROUTINE_CALL) op = OP_SUBROUTINE_CALL;
		else if ((ir & MASK_11BIT) == OPC_ABSOLUTE_JUMP) op = OP_ABSOLUTE_JUMP;
		return op;
	endfunction : decodeOp

endpackage : decoder_pkg

`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
	typedef struct {
		logic [14:0] pc;
		logic [7:0] work;
		logic [2:0] flg;
		logic [1:0] todp;
		logic [7:0] pre;
		logic [7:0][7:0] dir;
		logic ie;
		logic [15:0] addr;
		logic useAddr;
		logic [3:0] pulses;
		logic [7:0] wdata;
		int clocks;
	} note_t;

	logic sys_clk;
	logic reset_n;
	logic instrValid;
	logic [13:0] instr;
	logic instrReady;
	logic [14:0] pcOut;
	logic [15:0] memAddr;
	wire logic [7:0] memRdData;
	logic [7:0] memWrData;
	logic memWrEn;
	logic [7:0] workOut;
	logic carryFlag;
	logic halfCarryFlag;
	logic zeroFlag;
	logic watchdogExpiredFlag;
	logic powerDownFlag;
	logic intEnable;
	logic [7:0] prescalerConfig;
	logic [7:0][7:0] dirRegs;
	logic wdtClear;
	logic standbyReq;
	logic softResetReq;

	note_t e;
	note_t n;
	note_t notes[$];
	logic [14:0] stk[$];
	logic [15:0] ptr [2];
	logic [2:0] sel [5] = '{3'h0, 3'h1, 3'h5, 3'h6, 3'h7};
	logic [8:0] rel [3] = '{9'h0ff, 9'h100, 9'h000};
	int miscompares;
	int checksDone;
	int count;
	int gotClk;
	int cycles;
	int i;
	integer seed;
	logic inFlight;
	logic due;
	logic [3:0] seen;
	logic [3:0] gotSeen;
	logic [7:0] wdSeen;
	logic [7:0] gotWd;
	logic [14:0] t;
	logic [14:0] gotPc;

	// The data memory answers combinationally with the two address bytes XORed together and with 8'h5a.
	assign memRdData = memAddr[7:0] ^ memAddr[15:8] ^ 8'h5a;

	control_inherent_op_decoder u_control_inherent_op_decoder (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.instrValid(instrValid),
		.instr(instr),
		.instrReady(instrReady),
		.pcOut(pcOut),
		.memAddr(memAddr),
		.memRdData(memRdData),
		.memWrData(memWrData),
		.memWrEn(memWrEn),
		.workOut(workOut),
		.carryFlag(carryFlag),
		.halfCarryFlag(halfCarryFlag),
		.zeroFlag(zeroFlag),
		.watchdogExpiredFlag(watchdogExpiredFlag),
		.powerDownFlag(powerDownFlag),
		.intEnable(intEnable),
		.prescalerConfig(prescalerConfig),
		.dirRegs(dirRegs),
		.wdtClear(wdtClear),
		.standbyReq(standbyReq),
		.softResetReq(softResetReq)
	);

	function logic [7:0] memVal(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5a;
	endfunction : memVal

	function logic [14:0] pc1();
		return e.pc + 15'h0001;
	endfunction : pc1

	task chk(input logic bad, input string msg);
		checksDone++;
		if (bad)
		begin
			miscompares++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask : chk

	task complete_run();
		if (miscompares == 0 && checksDone > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : complete_run

	// Junk on instr while not valid shows that unqualified words leave no trace.
	task issue(input logic [13:0] op, input int clocks, input logic [14:0] npc);
		e.clocks = clocks;
		e.pc = npc;
		while (instrReady !== 1'b1)
		begin
			@(posedge sys_clk);
			#1;
		end
		instrValid = 1'b1;
		instr = op;
		notes.push_back(e);
		@(posedge sys_clk);
		#1;
		instrValid = 1'b0;
		instr = 14'($random(seed));
		e.useAddr = 1'b0;
		e.pulses = 4'h0;
	endtask : issue

	task ctl(input logic [13:0] op, input logic [14:0] npc);
		issue(op, 8, npc);
	endtask : ctl

	task inh(input logic [13:0] op, input logic [3:0] pulses);
		e.pulses = pulses;
		issue(op, 4, pc1());
	endtask : inh

	task addLit(input logic [7:0] k);
		logic [8:0] s;
		logic [4:0] h;
		s = {1'b0, e.work} + {1'b0, k};
		h = {1'b0, e.work[3:0]} + {1'b0, k[3:0]};
		e.work = s[7:0];
		e.flg = {s[8], h[4], s[7:0] == 8'h00};
		issue(decoder_pkg::OPC_ADD_LITERAL | {6'h00, k}, 4, pc1());
	endtask : addLit

	task andLit(input logic [7:0] k);
		e.work = e.work & k;
		e.flg[0] = (e.work == 8'h00);
		issue(decoder_pkg::OPC_AND_LITERAL | {6'h00, k}, 4, pc1());
	endtask : andLit

	task pa(input logic p, input logic [5:0] k);
		ptr[p] = ptr[p] + {{10{k[5]}}, k};
		issue(decoder_pkg::OPC_POINTER_ADD | {7'h00, p, k}, 4, pc1());
	endtask : pa

	// The extra cycle follows the pointer's top bit before any stepping.
	task access(input logic [13:0] op, input logic [15:0] a, input logic msb, input logic wr,
		input logic [7:0] v, input logic z);
		e.useAddr = 1'b1;
		e.addr = a;
		if (wr)
		begin
			e.pulses = 4'b1000;
			e.wdata = v;
		end
		else
			e.work = v;
		if (z)
			e.flg[0] = (v == 8'h00);
		issue(op, msb ? 8 : 4, pc1());
	endtask : access

	task idx(input logic st, input logic p, input logic [5:0] k);
		logic [15:0] a;
		a = ptr[p] + {{10{k[5]}}, k};
		access((st ? decoder_pkg::OPC_INDIRECT_STORE_IDX : decoder_pkg::OPC_INDIRECT_LOAD_IDX)
			| {7'h00, p, k}, a, ptr[p][15], st, st ? e.work : memVal(a), !st);
	endtask : idx

	task modOp(input logic st, input logic p, input logic [1:0] mm);
		logic [15:0] old;
		logic [15:0] a;
		old = ptr[p];
		ptr[p] = mm[0] ? old - 16'h0001 : old + 16'h0001;
		a = mm[1] ? old : ptr[p];
		access((st ? decoder_pkg::OPC_INDIRECT_STORE_MOD : decoder_pkg::OPC_INDIRECT_LOAD_MOD)
			| {11'h000, p, mm}, a, old[15], st, st ? e.work : memVal(a), !st);
	endtask : modOp

	task andFile(input logic d, input logic [6:0] f);
		logic [15:0] a;
		a = (f < 7'h02) ? ptr[f[0]] : {9'h000, f};
		access(decoder_pkg::OPC_AND_FILE | {6'h00, d, f}, a, (f < 7'h02) && ptr[f[0]][15], d,
			e.work & memVal(a), 1'b1);
	endtask : andFile

	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			miscompares++;
			complete_run();
		end
	end

	always @(posedge sys_clk)
	begin
		if (inFlight)
		begin
			count++;
			seen = seen | {memWrEn, wdtClear, standbyReq, softResetReq};
			if (memWrEn === 1'b1)
				wdSeen = memWrData;
			if (instrReady === 1'b1)
			begin
				due = 1'b1;
				gotClk = count;
				// The next take bumps the counter on this same edge, so keep the settled value.
				gotPc = pcOut;
				gotSeen = seen;
				gotWd = wdSeen;
				inFlight = 1'b0;
			end
		end
		if (instrReady === 1'b1 && instrValid === 1'b1 && reset_n === 1'b1)
		begin
			inFlight = 1'b1;
			count = 0;
			seen = 4'h0;
		end
	end

	always @(negedge sys_clk)
	begin
		if (due)
		begin
			due = 1'b0;
			if (notes.size() == 0)
				chk(1'b1, "completion without instruction");
			else
			begin
				n = notes.pop_front();
				chk(gotClk != n.clocks, "instruction cycle length");
				chk(gotPc !== n.pc, "program counter");
				chk(workOut !== n.work, "working register");
				chk({carryFlag, halfCarryFlag, zeroFlag} !== n.flg, "status flags");
				chk({watchdogExpiredFlag, powerDownFlag} !== n.todp, "power flags");
				chk(gotSeen !== n.pulses, "pulse outputs");
				chk(n.pulses[3] === 1'b1 && gotWd !== n.wdata, "write data");
				chk(n.useAddr === 1'b1 && memAddr !== n.addr, "data address");
				chk(prescalerConfig !== n.pre, "prescaler config");
				chk(dirRegs !== n.dir, "direction registers");
				chk(intEnable !== n.ie, "interrupt enable");
			end
		end
	end

	initial
	begin
		seed = 32'h0000001f;
		reset_n = 1'b0;
		instrValid = 1'b0;
		instr = 14'h0000;
		inFlight = 1'b0;
		due = 1'b0;
		miscompares = 0;
		checksDone = 0;
		cycles = 0;
		ptr[0] = 16'h0000;
		ptr[1] = 16'h0000;
		e = '{pc: 15'h0000, work: 8'h00, flg: 3'h0, todp: 2'h3, pre: 8'hff,
			dir: 64'hffff_ffff_ffff_ffff, ie: 1'b0, addr: 16'h0000, useAddr: 1'b0,
			pulses: 4'h0, wdata: 8'h00, clocks: 4};
		repeat (2) @(posedge sys_clk);
		#1;
		reset_n = 1'b1;
		for (i = 0; i < 6; i++)
			addLit((i == 3) ? 8'h00 - e.work : 8'($random(seed)));
		andLit(8'($random(seed)));
		andLit(8'h00);
		ctl(decoder_pkg::OPC_ABSOLUTE_JUMP | 14'h0123, {e.pc[14:11], 11'h123});
		for (i = 0; i < 3; i++)
			ctl(decoder_pkg::OPC_RELATIVE_JUMP | {5'h00, rel[i]}, pc1() + {{6{rel[i][8]}}, rel[i]});
		stk.push_back(pc1());
		ctl(decoder_pkg::OPC_SUBROUTINE_CALL | 14'h0050, {e.pc[14:11], 11'h050});
		e.work = 8'ha5;
		ctl(decoder_pkg::OPC_RETURN_WITH_LITERAL | 14'h00a5, stk.pop_back());
		addLit(8'h10);
		t = pc1();
		stk.push_back(t);
		ctl(decoder_pkg::OPC_SUBROUTINE_BY_WORKING, {t[14:8], e.work});
		ctl(decoder_pkg::OPC_RETURN, stk.pop_back());
		ctl(decoder_pkg::OPC_JUMP_BY_WORKING, pc1() + {7'h00, e.work});
		stk.push_back(pc1());
		ctl(decoder_pkg::OPC_SUBROUTINE_CALL | 14'h0200, {e.pc[14:11], 11'h200});
		e.ie = 1'b1;
		ctl(decoder_pkg::OPC_INTERRUPT_EXIT, stk.pop_back());
		e.todp = 2'b10;
		inh(decoder_pkg::OPC_SLEEP, 4'b0010);
		e.todp = 2'b11;
		inh(decoder_pkg::OPC_KICK_WATCHDOG, 4'b0100);
		e.pre = e.work;
		inh(decoder_pkg::OPC_LOAD_PRESCALER, 4'h0);
		inh(decoder_pkg::OPC_SOFT_RESET, 4'b0001);
		inh(14'h0000, 4'h0);
		for (i = 0; i < 5; i++)
		begin
			addLit(8'($random(seed)));
			e.dir[sel[i]] = e.work;
			inh(decoder_pkg::OPC_LOAD_DIRECTION | {11'h000, sel[i]}, 4'h0);
		end
		pa(1'b0, 6'h3f);
		idx(1'b1, 1'b0, 6'h00);
		pa(1'b0, 6'h01);
		modOp(1'b0, 1'b0, decoder_pkg::MOD_POST_INC);
		modOp(1'b1, 1'b0, decoder_pkg::MOD_PRE_DEC);
		idx(1'b0, 1'b0, 6'h20);
		idx(1'b1, 1'b0, 6'h1f);
		pa(1'b1, 6'h20);
		for (i = 0; i < 4; i++)
			modOp(i[0], 1'b1, i[1:0]);
		andFile(1'b0, 7'h10);
		andFile(1'b1, 7'h7f);
		andFile(1'b0, 7'h01);
		andFile(1'b1, 7'h00);
		i = 0;
		while ((notes.size() != 0 || inFlight || due) && i < 100)
		begin
			@(posedge sys_clk);
			i++;
		end
		@(posedge sys_clk);
		chk(notes.size() != 0, "instructions never completed");
		complete_run();
	end
endmodule : tb

`default_nettype wire
